// ---- shared/qlc_defines.svh ----
// Offsets, field positions, reset values and codes of the control registers
`ifndef QLC_DEFINES_SVH
`define QLC_DEFINES_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define QLC_ADDR_MONITOR_POINT_SELECT    8'h0B
`define QLC_ADDR_DIGITAL_LOOPBACK_ENABLE 8'h0C
`define QLC_ADDR_LOSS_ALARM_CRITERIA     8'h0D
`define QLC_ADDR_AUTO_ALL_ONES_SELECT    8'h0E
`define QLC_ADDR_GLOBAL_CONTROL          8'h0F
`define QLC_ADDR_PATH_STATUS             8'h1F

// ----------------------------------------------------------------
// Widths and reset values
// ----------------------------------------------------------------
`define QLC_CHANNELS     4
`define QLC_CHAN_RESET   4'h0
`define QLC_GLOBAL_RESET 7'h00
`define QLC_READ_ZERO    8'h00

// ----------------------------------------------------------------
// Global control field positions
// ----------------------------------------------------------------
`define QLC_GC_ATTEN_ENABLE  0
`define QLC_GC_ATTEN_PATH    1
`define QLC_GC_ATTEN_CORNER  2
`define QLC_GC_ATTEN_DEPTH   3
`define QLC_GC_LINE_CODE     4
`define QLC_GC_SHORT_DISABLE 5
`define QLC_GC_RX_ALARM      6

// ----------------------------------------------------------------
// Pulse shape length code that means E1
// ----------------------------------------------------------------
`define QLC_LEN_E1 3'h0

`endif

// ---- shared/qlc_pkg.sv ----
// Types shared by the control register bank
`default_nettype none

package qlc_pkg;

    typedef enum logic [1:0] {
        QLC_ATTEN_OFF = 2'b00,
        QLC_ATTEN_TX  = 2'b01,
        QLC_ATTEN_RX  = 2'b10
    } qlc_atten_pos_t;

    typedef enum logic {
        QLC_MODE_T1 = 1'b0,
        QLC_MODE_E1 = 1'b1
    } qlc_mode_t;

    // Enable bit low disables regardless of the path bit
    function automatic qlc_atten_pos_t qlc_atten_decode(
        input logic enableBit,
        input logic pathBit
    );
        if (!enableBit) begin
            return QLC_ATTEN_OFF;
        end
        return pathBit ? QLC_ATTEN_RX : QLC_ATTEN_TX;
    endfunction

endpackage

`default_nettype wire

// ---- shared/qlc_chan_if.sv ----
// Interface between the register bank and the channel data path
`default_nettype none

interface qlc_chan_if #(
    parameter int CHANNELS = 4
);
    logic [CHANNELS-1:0] loopEn;
    logic [CHANNELS-1:0] autoOnesEn;
    logic                aisInsertEn;
    logic                dataRecovery;
    logic [CHANNELS-1:0] sendingOnes;
    logic [CHANNELS-1:0] insertingAis;

    modport ctrl (
        output loopEn,
        output autoOnesEn,
        output aisInsertEn,
        output dataRecovery,
        input  sendingOnes,
        input  insertingAis
    );

    modport path (
        input  loopEn,
        input  autoOnesEn,
        input  aisInsertEn,
        input  dataRecovery,
        output sendingOnes,
        output insertingAis
    );
endinterface

`default_nettype wire

// ---- core/qlc_channel_path.sv ----
// Per-channel loopback, all-ones and receive alarm selection
`default_nettype none

module qlc_channel_path #(
    parameter int CHANNELS = 4
) (
    input  wire logic                clk,
    input  wire logic                srst,
    qlc_chan_if.path                 cfg,
    input  wire logic [CHANNELS-1:0] losDetect,
    input  wire logic [CHANNELS-1:0] txPos,
    input  wire logic [CHANNELS-1:0] txNeg,
    input  wire logic [CHANNELS-1:0] txClk,
    input  wire logic [CHANNELS-1:0] lineRxPos,
    input  wire logic [CHANNELS-1:0] lineRxNeg,
    input  wire logic [CHANNELS-1:0] lineRxClk,
    output logic      [CHANNELS-1:0] next_rxPos,
    output logic      [CHANNELS-1:0] next_rxNeg,
    output logic      [CHANNELS-1:0] next_rxClk,
    output logic      [CHANNELS-1:0] next_lineTxPos,
    output logic      [CHANNELS-1:0] next_lineTxNeg
);
    // Mark polarity runs on the system clock, never on transmit clock
    logic markPhase;

    always_ff @(posedge clk) begin
        if (srst) begin
            markPhase <= 1'b0;
        end else begin
            markPhase <= ~markPhase;
        end
    end

    always_comb begin
        cfg.sendingOnes  = cfg.autoOnesEn & losDetect; // [R8] [R20]
        cfg.insertingAis = (cfg.aisInsertEn && !cfg.dataRecovery) ?
                           losDetect : '0; // [R15] [R16]
        for (int i = 0; i < CHANNELS; i++) begin
            // Continuous marks, alternating polarity
            if (cfg.sendingOnes[i]) begin
                next_lineTxPos[i] = markPhase; // [R19]
                next_lineTxNeg[i] = ~markPhase; // [R19]
            end else begin
                next_lineTxPos[i] = txPos[i];
                next_lineTxNeg[i] = txNeg[i];
            end
            if (cfg.loopEn[i]) begin
                next_rxPos[i] = txPos[i]; // [R3]
                next_rxNeg[i] = txNeg[i]; // [R3]
                next_rxClk[i] = txClk[i]; // [R3]
            end else if (cfg.insertingAis[i]) begin
                next_rxPos[i] = markPhase;
                next_rxNeg[i] = ~markPhase;
                next_rxClk[i] = lineRxClk[i];
            end else begin
                next_rxPos[i] = lineRxPos[i];
                next_rxNeg[i] = lineRxNeg[i];
                next_rxClk[i] = lineRxClk[i];
            end
        end
    end
endmodule

`default_nettype wire

// ---- core/qlc_control_regs.sv ----
// Control register bank of a quad line interface with channel paths
//
// Design decision made here: strobed register access.
`include "qlc_defines.svh"
`default_nettype none

// What this block does
// [R1] Monitor register low nibble picks the observed monitoring point.
// [R2] Each loopback bit enables digital loopback on its channel.
// [R3] Loopback returns transmit pair and clock on receive outputs.
// [R4] In T1 the criteria bits are ignored; T1 standard detection used.
// [R5] In E1 a criteria bit of one selects ETSI, zero G.775 LOS.
// [R6] Criteria bit zero gives alarm detection valid for ETSI and ITU.
// [R7] T1 or E1 mode comes from the pulse shape length code.
// [R8] Auto all-ones bit makes its channel send ones on loss of signal.
// [R9] Software writes zero to upper auto all-ones bits.
// [R10] Two select bits place the attenuator on transmit, receive or off.
// [R11] Global bit 2 chooses the attenuator corner frequency.
// [R12] Global bit 3 chooses a 32 or 64 bit attenuator FIFO.
// [R13] Global bit 4 chooses zero suppression code or plain AMI.
// [R14] Global bit 5 set disables transmit short-circuit protection.
// [R15] Global bit 6 inserts receive alarm on loss of signal.
// [R16] Receive alarm insertion is off in data recovery mode.
// [R17] Software masks alarm interrupts before changing insertion bit.
// [R18] All these registers clear to zero on reset.
// [R19] All ones means a continuous stream of marks on the line.
// [R20] Loss of signal is the channel monitor's valid detection.
// [R21] Reserved bits read zero and writes to them do nothing.
module qlc_control_regs #(
    parameter int CHANNELS = `QLC_CHANNELS
) (
    input  wire logic                clk,
    input  wire logic                srst,
    input  wire logic [7:0]          regAddr,
    input  wire logic [7:0]          regWrData,
    input  wire logic                regWr,
    input  wire logic                regRd,
    output logic      [7:0]          regRdData,
    input  wire logic [2:0]          pulseShapeDataLen,
    input  wire logic                masterClkHigh,
    input  wire logic [CHANNELS-1:0] losDetect,
    input  wire logic [CHANNELS-1:0] transmitPositiveData,
    input  wire logic [CHANNELS-1:0] transmitNegativeData,
    input  wire logic [CHANNELS-1:0] transmitClock,
    input  wire logic [CHANNELS-1:0] lineRxPos,
    input  wire logic [CHANNELS-1:0] lineRxNeg,
    input  wire logic [CHANNELS-1:0] lineRxClk,
    output logic      [CHANNELS-1:0] receivePositiveData,
    output logic      [CHANNELS-1:0] receiveNegativeData,
    output logic      [CHANNELS-1:0] receiveClock,
    output logic      [CHANNELS-1:0] lineTxPos,
    output logic      [CHANNELS-1:0] lineTxNeg,
    output logic      [3:0]          monitorSelect,
    output logic      [1:0]          attenuatorPosition,
    output logic                     attenuatorCorner,
    output logic                     attenuatorDepth64,
    output logic                     lineCodeAmi,
    output logic                     shortProtectEnable,
    output logic                     losT1Standard,
    output logic      [CHANNELS-1:0] losEtsiSelect,
    output logic      [CHANNELS-1:0] aisDualCompliant
);

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [3:0]          monitorSelectField;
    logic [CHANNELS-1:0] loopbackChannelBits;
    logic [CHANNELS-1:0] criteriaChannelBits;
    logic [CHANNELS-1:0] autoOnesChannelBits;
    logic [6:0]          globalControl;

    // ------------------------------------------------------------
    // Derived state
    // ------------------------------------------------------------
    qlc_pkg::qlc_mode_t      lineMode;
    qlc_pkg::qlc_atten_pos_t next_attenPos;
    logic [CHANNELS-1:0]     next_rxPos;
    logic [CHANNELS-1:0]     next_rxNeg;
    logic [CHANNELS-1:0]     next_rxClk;
    logic [CHANNELS-1:0]     next_lineTxPos;
    logic [CHANNELS-1:0]     next_lineTxNeg;
    logic [7:0]              next_regRdData;

    qlc_chan_if #(.CHANNELS(CHANNELS)) chanCfg ();

    // ------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------
    function automatic logic wrHit(
        input logic       wr,
        input logic [7:0] addr,
        input logic [7:0] target
    );
        return wr && (addr == target);
    endfunction

    always_ff @(posedge clk) begin
        if (srst) begin
            monitorSelectField <= 4'h0;
        end else if (wrHit(regWr, regAddr,
                           `QLC_ADDR_MONITOR_POINT_SELECT)) begin
            monitorSelectField <= regWrData[3:0]; // [R1] [R21]
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            loopbackChannelBits <= `QLC_CHAN_RESET; // [R18]
        end else if (wrHit(regWr, regAddr,
                           `QLC_ADDR_DIGITAL_LOOPBACK_ENABLE)) begin
            loopbackChannelBits <= regWrData[CHANNELS-1:0]; // [R2]
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            criteriaChannelBits <= `QLC_CHAN_RESET; // [R18]
        end else if (wrHit(regWr, regAddr,
                           `QLC_ADDR_LOSS_ALARM_CRITERIA)) begin
            criteriaChannelBits <= regWrData[CHANNELS-1:0];
        end
    end

    // Upper nibble is not stored, so a nonzero write is harmless
    always_ff @(posedge clk) begin
        if (srst) begin
            autoOnesChannelBits <= `QLC_CHAN_RESET; // [R18]
        end else if (wrHit(regWr, regAddr,
                           `QLC_ADDR_AUTO_ALL_ONES_SELECT)) begin
            autoOnesChannelBits <= regWrData[CHANNELS-1:0]; // [R8]
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            globalControl <= `QLC_GLOBAL_RESET; // [R18]
        end else if (wrHit(regWr, regAddr,
                           `QLC_ADDR_GLOBAL_CONTROL)) begin
            globalControl <= regWrData[6:0]; // [R21]
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    always_comb begin
        next_regRdData = `QLC_READ_ZERO;
        case (regAddr)
            `QLC_ADDR_MONITOR_POINT_SELECT: begin
                next_regRdData[3:0] = monitorSelectField; // [R21]
            end
            `QLC_ADDR_DIGITAL_LOOPBACK_ENABLE: begin
                next_regRdData[CHANNELS-1:0] = loopbackChannelBits;
            end
            `QLC_ADDR_LOSS_ALARM_CRITERIA: begin
                next_regRdData[CHANNELS-1:0] = criteriaChannelBits;
            end
            `QLC_ADDR_AUTO_ALL_ONES_SELECT: begin
                next_regRdData[CHANNELS-1:0] = autoOnesChannelBits;
            end
            `QLC_ADDR_GLOBAL_CONTROL: begin
                next_regRdData[6:0] = globalControl; // [R21]
            end
            `QLC_ADDR_PATH_STATUS: begin
                next_regRdData[3:0] = chanCfg.sendingOnes;
                next_regRdData[7:4] = chanCfg.insertingAis;
            end
            default: begin
                next_regRdData = `QLC_READ_ZERO;
            end
        endcase
    end

    // Data shows only in the cycle after a read strobe
    always_ff @(posedge clk) begin
        if (srst) begin
            regRdData <= `QLC_READ_ZERO;
        end else if (regRd) begin
            regRdData <= next_regRdData;
        end else begin
            regRdData <= `QLC_READ_ZERO;
        end
    end

    // ------------------------------------------------------------
    // Line mode and loss criteria
    // ------------------------------------------------------------
    assign lineMode = (pulseShapeDataLen == `QLC_LEN_E1) ?
                      qlc_pkg::QLC_MODE_E1 : qlc_pkg::QLC_MODE_T1; // [R7]

    always_ff @(posedge clk) begin
        if (srst) begin
            losT1Standard <= 1'b0;
        end else begin
            losT1Standard <= (lineMode == qlc_pkg::QLC_MODE_T1); // [R4]
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            losEtsiSelect    <= '0;
            aisDualCompliant <= '0;
        end else if (lineMode == qlc_pkg::QLC_MODE_E1) begin
            losEtsiSelect    <= criteriaChannelBits; // [R5]
            aisDualCompliant <= ~criteriaChannelBits; // [R6]
        end else begin
            losEtsiSelect    <= '0; // [R4]
            aisDualCompliant <= '0;
        end
    end

    // ------------------------------------------------------------
    // Global settings
    // ------------------------------------------------------------
    assign next_attenPos = qlc_pkg::qlc_atten_decode(
        globalControl[`QLC_GC_ATTEN_ENABLE],
        globalControl[`QLC_GC_ATTEN_PATH]); // [R10]

    always_ff @(posedge clk) begin
        if (srst) begin
            monitorSelect <= 4'h0;
        end else begin
            monitorSelect <= monitorSelectField; // [R1]
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            attenuatorPosition <= qlc_pkg::QLC_ATTEN_OFF;
        end else begin
            attenuatorPosition <= next_attenPos; // [R10]
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            attenuatorCorner <= 1'b0;
        end else begin
            attenuatorCorner <=
                globalControl[`QLC_GC_ATTEN_CORNER]; // [R11]
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            attenuatorDepth64 <= 1'b0;
        end else begin
            attenuatorDepth64 <=
                globalControl[`QLC_GC_ATTEN_DEPTH]; // [R12]
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            lineCodeAmi <= 1'b0;
        end else begin
            lineCodeAmi <=
                globalControl[`QLC_GC_LINE_CODE]; // [R13]
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            shortProtectEnable <= 1'b1;
        end else begin
            shortProtectEnable <=
                ~globalControl[`QLC_GC_SHORT_DISABLE]; // [R14]
        end
    end

    // ------------------------------------------------------------
    // Channel paths
    // ------------------------------------------------------------
    assign chanCfg.loopEn       = loopbackChannelBits; // [R2]
    assign chanCfg.autoOnesEn   = autoOnesChannelBits; // [R8]
    assign chanCfg.aisInsertEn  =
        globalControl[`QLC_GC_RX_ALARM]; // [R15]
    assign chanCfg.dataRecovery = masterClkHigh; // [R16]

    qlc_channel_path #(
        .CHANNELS (CHANNELS)
    ) chanPath (
        .clk            (clk),
        .srst           (srst),
        .cfg            (chanCfg),
        .losDetect      (losDetect),
        .txPos          (transmitPositiveData),
        .txNeg          (transmitNegativeData),
        .txClk          (transmitClock),
        .lineRxPos      (lineRxPos),
        .lineRxNeg      (lineRxNeg),
        .lineRxClk      (lineRxClk),
        .next_rxPos     (next_rxPos),
        .next_rxNeg     (next_rxNeg),
        .next_rxClk     (next_rxClk),
        .next_lineTxPos (next_lineTxPos),
        .next_lineTxNeg (next_lineTxNeg)
    );

    // All-ones sending keeps running while a channel loops back; loopback wins over receive alarm insertion
    always_ff @(posedge clk) begin
        if (srst) begin
            receivePositiveData <= '0;
        end else begin
            receivePositiveData <= next_rxPos; // [R3]
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            receiveNegativeData <= '0;
        end else begin
            receiveNegativeData <= next_rxNeg;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            receiveClock <= '0;
        end else begin
            receiveClock <= next_rxClk;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            lineTxPos <= '0;
        end else begin
            lineTxPos <= next_lineTxPos; // [R19]
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            lineTxNeg <= '0;
        end else begin
            lineTxNeg <= next_lineTxNeg;
        end
    end

endmodule

`default_nettype wire

// ---- testbench/qlc_control_regs_checker.sv ----
// Port-level assertions for the control register bank
`default_nettype none

module qlc_control_regs_checker #(
    parameter int CHANNELS = 4
) (
    input wire logic                clk,
    input wire logic                srst,
    input wire logic [7:0]          regAddr,
    input wire logic [7:0]          regWrData,
    input wire logic                regWr,
    input wire logic                regRd,
    input wire logic [7:0]          regRdData,
    input wire logic [2:0]          pulseShapeDataLen,
    input wire logic                masterClkHigh,
    input wire logic [CHANNELS-1:0] losDetect,
    input wire logic [CHANNELS-1:0] transmitPositiveData,
    input wire logic [CHANNELS-1:0] receivePositiveData,
    input wire logic [CHANNELS-1:0] receiveNegativeData,
    input wire logic [CHANNELS-1:0] lineTxPos,
    input wire logic [CHANNELS-1:0] lineTxNeg,
    input wire logic [3:0]          monitorSelect,
    input wire logic [1:0]          attenuatorPosition,
    input wire logic                shortProtectEnable,
    input wire logic                losT1Standard,
    input wire logic [CHANNELS-1:0] losEtsiSelect,
    input wire logic [CHANNELS-1:0] aisDualCompliant
);
    logic [3:0]          mon;
    logic [CHANNELS-1:0] lb;
    logic [CHANNELS-1:0] cr;
    logic [CHANNELS-1:0] ao;
    logic [6:0]          gc;
    logic [CHANNELS-1:0] onesReq;
    logic [CHANNELS-1:0] aisReq;
    logic [1:0]          expAtten;
    logic                isMapped;

    // ------------------------------------------------------------
    // Shadow of the writable registers
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (srst) begin
            mon <= 4'h0;
            lb  <= '0;
            cr  <= '0;
            ao  <= '0;
            gc  <= 7'h00;
        end else if (regWr) begin
            case (regAddr)
                8'h0B: mon <= regWrData[3:0];
                8'h0C: lb <= regWrData[CHANNELS-1:0];
                8'h0D: cr <= regWrData[CHANNELS-1:0];
                8'h0E: ao <= regWrData[CHANNELS-1:0];
                8'h0F: gc <= regWrData[6:0];
                default: ;
            endcase
        end
    end

    assign onesReq  = ao & losDetect;
    assign aisReq   = {CHANNELS{gc[6] & ~masterClkHigh}} & losDetect & ~lb;
    assign expAtten = gc[0] ? (gc[1] ? 2'b10 : 2'b01) : 2'b00;
    assign isMapped = (regAddr >= 8'h0B && regAddr <= 8'h0F)
                   || regAddr == 8'h1F;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (srst);

    a_reset_clear: assert property (
        disable iff (1'b0) srst |=> regRdData == 8'h00
        && monitorSelect == 4'h0 && shortProtectEnable)
        else $error("outputs not cleared by reset");
    a_read_idle: assert property (
        !$past(regRd) |-> regRdData == 8'h00)
        else $error("read data outside read cycle");
    a_unmapped_zero: assert property (
        regRd && !isMapped |=> regRdData == 8'h00)
        else $error("unmapped read not zero");
    a_monitor_follow: assert property (
        !$past(srst) |-> monitorSelect == $past(mon))
        else $error("monitor select mismatch");
    a_atten_place: assert property (
        !$past(srst) |-> attenuatorPosition == $past(expAtten))
        else $error("attenuator position mismatch");
    a_short_protect: assert property (
        !$past(srst) |-> shortProtectEnable != $past(gc[5]))
        else $error("short protection mismatch");
    a_mode_select: assert property (
        !$past(srst) |-> losT1Standard == ($past(pulseShapeDataLen) != 3'h0))
        else $error("line mode mismatch");
    a_t1_ignore: assert property (
        losT1Standard |-> losEtsiSelect == '0 && aisDualCompliant == '0)
        else $error("criteria used in T1");
    a_e1_criteria: assert property (
        !$past(srst) && !losT1Standard |-> losEtsiSelect == $past(cr)
        && aisDualCompliant == ~losEtsiSelect)
        else $error("E1 criteria mismatch");
    a_loop_return: assert property (
        !$past(srst) |-> (receivePositiveData & $past(lb))
        == ($past(transmitPositiveData) & $past(lb)))
        else $error("loopback data mismatch");
    a_ones_marks: assert property (
        !$past(srst) |-> ((lineTxPos ^ lineTxNeg) & $past(onesReq))
        == $past(onesReq))
        else $error("all ones marks missing");
    a_ais_insert: assert property (
        !$past(srst) |-> ((receivePositiveData ^ receiveNegativeData)
        & $past(aisReq)) == $past(aisReq))
        else $error("receive alarm missing");
endmodule

`default_nettype wire

// ---- testbench/quad_line_interface_control_regs_bench.sv ----
// Self-checking bench for the control register bank
`default_nettype none

module quad_line_interface_control_regs_bench;
    timeunit 1ns;
    timeprecision 100ps;

    logic       clk, srst, regWr, regRd, masterClkHigh;
    logic [7:0] regAddr, regWrData, regRdData, rd;
    logic [2:0] len;
    logic [3:0] los, txPos, txNeg, txClk, rxPos, rxNeg, rxClk, p;
    logic [3:0] receive_positive_data, receive_negative_data, rClk, lTxPos, lTxNeg, monSel, losEtsi, aisDual;
    logic [1:0] attPos;
    logic       corner, depth, ami, shortEn, t1Std;
    int         mismatches, nChecks;
    logic [23:0] rows [8] = '{24'h0B_FF_0F, 24'h0C_A5_05, 24'h0D_3C_0C,
        24'h0E_03_03, 24'h0F_FF_7F, 24'h10_FF_00, 24'h0A_55_00, 24'h1F_FF_00};
    logic [1:0]  att [4] = '{2'b00, 2'b01, 2'b00, 2'b10};

    qlc_control_regs DUT (
        .clk(clk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
        .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
        .pulseShapeDataLen(len), .masterClkHigh(masterClkHigh),
        .losDetect(los), .transmitPositiveData(txPos),
        .transmitNegativeData(txNeg), .transmitClock(txClk),
        .lineRxPos(rxPos), .lineRxNeg(rxNeg), .lineRxClk(rxClk),
        .receivePositiveData(receive_positive_data), .receiveNegativeData(receive_negative_data),
        .receiveClock(rClk), .lineTxPos(lTxPos), .lineTxNeg(lTxNeg),
        .monitorSelect(monSel), .attenuatorPosition(attPos),
        .attenuatorCorner(corner), .attenuatorDepth64(depth),
        .lineCodeAmi(ami), .shortProtectEnable(shortEn),
        .losT1Standard(t1Std), .losEtsiSelect(losEtsi),
        .aisDualCompliant(aisDual)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic testDone;
        if (mismatches == 0 && nChecks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        nChecks++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: saw %h wanted %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    task automatic rdReg(input logic [7:0] a);
        @(posedge clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 rd = regRdData;
    endtask

    // Next edge, then let its updates land
    task automatic cyc;
        @(posedge clk);
        #1;
    endtask

    initial begin
        #50000;
        mismatches++;
        testDone();
    end

    initial begin
        {regWr, regRd, masterClkHigh, regAddr, regWrData, len} = '0;
        {los, txPos, txNeg, txClk, rxPos, rxNeg, rxClk} = '0;
        srst = 1'b1;
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        for (int a = 8'h0B; a <= 8'h0F; a++) begin
            rdReg(a[7:0]);
            chk(rd, 8'h00);
        end
        chk(shortEn, 1'b1);
        for (int i = 0; i < 8; i++) begin
            wr(rows[i][23:16], rows[i][15:8]);
            rdReg(rows[i][23:16]);
            chk(rd, rows[i][7:0]);
        end
        chk(monSel, 4'hF);
        chk({corner, depth, ami, shortEn}, 4'hE);
        for (int i = 0; i < 4; i++) begin
            wr(8'h0F, i[7:0]);
            cyc();
            chk(attPos, att[i]);
        end
        wr(8'h0F, 8'h24);
        cyc();
        chk({corner, depth, ami, shortEn}, 4'h8);
        wr(8'h0F, 8'h18);
        cyc();
        chk({corner, depth, ami, shortEn}, 4'h7);
        wr(8'h0D, 8'h05);
        cyc();
        chk(losEtsi, 4'h5);
        chk(aisDual, 4'hA);
        for (int c = 3; c < 8; c++) begin
            @(posedge clk);
            len <= c[2:0];
            cyc();
            chk(t1Std, 1'b1);
            chk({losEtsi, aisDual}, 8'h00);
        end
        @(posedge clk);
        len <= 3'h0;
        wr(8'h0C, 8'h02);
        wr(8'h0E, 8'h02);
        wr(8'h0F, 8'h00);
        @(posedge clk);
        {txPos, txNeg, txClk} <= {4'hA, 4'h5, 4'h2};
        los <= 4'h6;
        cyc();
        chk({receive_positive_data, receive_negative_data}, 8'h20);
        chk(rClk, 4'h2);
        chk((lTxPos ^ lTxNeg) & 4'h2, 4'h2);
        p = lTxPos;
        cyc();
        chk(lTxPos & 4'h2, ~p & 4'h2);
        rdReg(8'h1F);
        chk(rd, 8'h02);
        wr(8'h0C, 8'h00);
        wr(8'h0F, 8'h40);
        cyc();
        chk(receive_positive_data ^ receive_negative_data, 4'h6);
        p = receive_positive_data;
        cyc();
        chk(receive_positive_data & 4'h6, ~p & 4'h6);
        rdReg(8'h1F);
        chk(rd, 8'h62);
        @(posedge clk);
        masterClkHigh <= 1'b1;
        cyc();
        chk({receive_positive_data, receive_negative_data}, 8'h00);
        @(posedge clk);
        masterClkHigh <= 1'b0;
        wr(8'h0F, 8'h00);
        cyc();
        chk({receive_positive_data, receive_negative_data}, 8'h00);
        wr(8'h0F, 8'h20);
        @(posedge clk);
        srst <= 1'b1;
        @(posedge clk);
        srst <= 1'b0;
        rdReg(8'h0E);
        chk(rd, 8'h00);
        chk(shortEn, 1'b1);
        testDone();
    end
endmodule

bind qlc_control_regs qlc_control_regs_checker #(.CHANNELS(CHANNELS)) u_chk (
    .clk(clk), .srst(srst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
    .pulseShapeDataLen(pulseShapeDataLen), .masterClkHigh(masterClkHigh),
    .losDetect(losDetect), .transmitPositiveData(transmitPositiveData),
    .receivePositiveData(receivePositiveData),
    .receiveNegativeData(receiveNegativeData),
    .lineTxPos(lineTxPos), .lineTxNeg(lineTxNeg),
    .monitorSelect(monitorSelect), .attenuatorPosition(attenuatorPosition),
    .shortProtectEnable(shortProtectEnable), .losT1Standard(losT1Standard),
    .losEtsiSelect(losEtsiSelect), .aisDualCompliant(aisDualCompliant)
);

`default_nettype wire
